/* File: rtl/pel_port_event_latches.sv */
// Purpose: event latch bank of one quad, with read-only and clear-on-read views
// Assumes: port inputs come from logic on ref_clk; the serial interface
//          logic delivers one-cycle read strobes with a byte address
// Notes:   summary bits 6:0 follow the latches ORed with ext_summary, so clearing latches clears them unless ext_summary is set
//
// Behaviour
// RL1: power-ok change per port sets bits 7:4
// RL2: switch-on change per port sets bits 3:0
// RL3: set change bits raise matching summary bits
// RL4: lower address reads plainly, next address clears
// RL5: class result update sets bits 7:4, class summary
// RL6: signature result update sets bits 3:0
// RL7: change-only option sets detect bit on difference
// RL8: detect bits raise detection-finished summary bit
// RL9: class event only after valid signature result
// RL10: maintain-current loss while powered sets disconnect bit
// RL11: overpower cutoff while powered sets fault bit
// RL12: overcurrent timeout while powered sets fault bit
// RL13: inrush timeout before power-ok sets start fault
// RL14: alert low when masked summary bit set
// RL15: clear-on-read clears corresponding summary bits
// RL16: event bits latch until cleared, reset zero
// RL17: new event beats simultaneous clear-on-read
`timescale 1ns/10ps
`default_nettype none

module pel_port_event_latches (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // port state machine status and events
  input  wire logic [3:0]                power_ok,
  input  wire logic [3:0]                switch_on,
  input  wire pel_pkg::pel_port_evt_type port_evt,
  // configuration and other clearing actions
  input  wire logic                      detect_change_only,
  input  wire logic [3:0]                port_clear,
  input  wire logic                      clear_all,
  // summary mask and summary bits owned by other blocks
  input  wire logic [7:0]                summary_mask,
  input  wire logic [7:0]                ext_summary,
  // register read port from the serial interface
  input  wire logic                      rd_strobe,
  input  wire logic [7:0]                rd_addr,
  output logic      [7:0]                rd_data,
  output logic                           rd_valid,
  // summary and alert
  output logic      [7:0]                event_summary,
  output logic                           alert_n
);
  import pel_pkg::*;

  logic [7:0] ev_q      [NUM_GROUPS];
  logic [7:0] next_ev   [NUM_GROUPS];
  logic [7:0] set_v     [NUM_GROUPS];
  logic [7:0] clr_v     [NUM_GROUPS];
  logic [3:0] pok_q;
  logic [3:0] son_q;
  logic [3:0] sig_q     [NUM_PORTS];
  logic [3:0] next_sig  [NUM_PORTS];
  logic [3:0] sig_valid;
  logic [3:0] det_set;
  logic [7:0] next_summary;
  logic [7:0] next_rd_data;
  logic       next_rd_valid;
  logic       next_alert_n;
  logic [7:0] port_clr_mask;

  // register address decode, shared by read data and clear logic
  function automatic logic in_event_map(input logic [7:0] a);
    return (a >= EVENT_BASE) && (a <= EVENT_LAST);
  endfunction

  function automatic logic [1:0] group_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - EVENT_BASE;
    return d[2:1];
  endfunction

  function automatic logic is_clr_view(input logic [7:0] a);
    return in_event_map(a) && a[0];
  endfunction

  assign port_clr_mask = {port_clear, port_clear};

  // event sources
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      sig_valid[p] = (port_evt.signature_result[p] == VALID_SIGNATURE);
      // repeated identical results are dropped in change-only mode
      det_set[p]   = port_evt.detect_update[p] &&
                     (!detect_change_only ||
                      (port_evt.signature_result[p] != sig_q[p])); // see RL7
      next_sig[p]  = port_evt.detect_update[p] ? port_evt.signature_result[p] : sig_q[p];
    end
    set_v[0] = {power_ok ^ pok_q,                                   // see RL1
                switch_on ^ son_q};                                 // see RL2
    set_v[1] = {port_evt.class_update & sig_valid,                  // see RL5 see RL9
                det_set};                                           // see RL6
    set_v[2] = {port_evt.maintain_loss_drop & pok_q,                // see RL10
                port_evt.overpower_trip & pok_q};                   // see RL11
    set_v[3] = {port_evt.overcurrent_trip & pok_q,                  // see RL12
                port_evt.inrush_trip & son_q & ~pok_q};             // see RL13
  end

  // latches: clear-on-read drops only the bits returned, new sets always win
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      clr_v[g] = port_clr_mask | {8{clear_all}};
      if (rd_strobe && is_clr_view(rd_addr) && (group_of(rd_addr) == g[1:0])) begin
        clr_v[g] = clr_v[g] | ev_q[g];                              // see RL4
      end
      next_ev[g] = (ev_q[g] & ~clr_v[g]) | set_v[g];                // see RL16 see RL17
    end
  end

  // summary follows the latches ORed with ext_summary, so a clear-on-read clears it unless ext_summary holds the bit
  always_comb begin
    next_summary = ext_summary;
    next_summary[SUM_SWITCH_ON_CHANGE] = ext_summary[SUM_SWITCH_ON_CHANGE] |
                                         (|next_ev[0][3:0]);       // see RL3
    next_summary[SUM_POWER_OK_CHANGE]  = ext_summary[SUM_POWER_OK_CHANGE] |
                                         (|next_ev[0][7:4]);       // see RL3 see RL15
    next_summary[SUM_CLASS_DONE]       = ext_summary[SUM_CLASS_DONE] |
                                         (|next_ev[1][7:4]);       // see RL5
    next_summary[SUM_DETECT_DONE]      = ext_summary[SUM_DETECT_DONE] |
                                         (|next_ev[1][3:0]);       // see RL8
    next_summary[SUM_DISCONNECT]       = ext_summary[SUM_DISCONNECT] |
                                         (|next_ev[2][7:4]);       // see RL10
    next_summary[SUM_POWER_FAULT]      = ext_summary[SUM_POWER_FAULT] |
                                         (|next_ev[2][3:0]) |       // see RL11
                                         (|next_ev[3][7:4]);       // see RL12
    next_summary[SUM_START_FAULT]      = ext_summary[SUM_START_FAULT] |
                                         (|next_ev[3][3:0]);       // see RL13
    // other quads pull their own alert; the board wires them together
    next_alert_n = ~|(next_summary & summary_mask);                 // see RL14
  end

  // read data, one cycle after the strobe; unmapped reads return zero
  always_comb begin
    next_rd_valid = rd_strobe;
    next_rd_data  = READ_IDLE;
    if (rd_strobe && in_event_map(rd_addr)) begin
      next_rd_data = ev_q[group_of(rd_addr)];                       // see RL4
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        ev_q[g] <= EVENT_RESET;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        sig_q[p] <= SIGNATURE_UNKNOWN;
      end
      pok_q         <= 4'h0;
      son_q         <= 4'h0;
      event_summary <= SUMMARY_RESET;
      alert_n       <= 1'b1;
      rd_data       <= READ_IDLE;
      rd_valid      <= 1'b0;
    end else begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        ev_q[g] <= next_ev[g];
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        sig_q[p] <= next_sig[p];
      end
      pok_q         <= power_ok;
      son_q         <= switch_on;
      event_summary <= next_summary;
      alert_n       <= next_alert_n;
      rd_data       <= next_rd_data;
      rd_valid      <= next_rd_valid;
    end
  end

  // checks
  property p_pok_change;
    @(posedge ref_clk) disable iff (!rstn)
      // the edge that lifts reset still finds the latches held in reset
      (rstn && (power_ok != pok_q)) |=> ((ev_q[0][7:4] & $past(power_ok ^ pok_q)) ==
                                         $past(power_ok ^ pok_q));
  endproperty
  a_pok_change: assert property (p_pok_change) // see RL1
    else $error("power-ok change not latched");

  property p_son_change;
    @(posedge ref_clk) disable iff (!rstn)
      (rstn && (switch_on != son_q)) |=> ((ev_q[0][3:0] & $past(switch_on ^ son_q)) ==
                                          $past(switch_on ^ son_q));
  endproperty
  a_son_change: assert property (p_son_change) // see RL2
    else $error("switch-on change not latched");

  property p_summary_pok;
    @(posedge ref_clk) disable iff (!rstn)
      (|ev_q[0][7:4]) |-> event_summary[SUM_POWER_OK_CHANGE];
  endproperty
  a_summary_pok: assert property (p_summary_pok) // see RL3
    else $error("power-ok summary bit missing");

  property p_plain_read_keeps;
    @(posedge ref_clk) disable iff (!rstn)
      (rd_strobe && in_event_map(rd_addr) && !rd_addr[0] && !clear_all &&
       (port_clear == 4'h0)) |=>
        (ev_q[group_of($past(rd_addr))] ==
         ($past(ev_q[group_of(rd_addr)]) | $past(set_v[group_of(rd_addr)]))) &&
        (rd_data == $past(ev_q[group_of(rd_addr)]));
  endproperty
  a_plain_read_keeps: assert property (p_plain_read_keeps) // see RL4
    else $error("read-only view disturbed latches");

  property p_clr_read;
    @(posedge ref_clk) disable iff (!rstn)
      (rd_strobe && is_clr_view(rd_addr)) |=>
        (rd_data == $past(ev_q[group_of(rd_addr)])) &&
        ((ev_q[group_of($past(rd_addr))] & $past(ev_q[group_of(rd_addr)]) &
          ~$past(set_v[group_of(rd_addr)])) == 8'h00);
  endproperty
  a_clr_read: assert property (p_clr_read) // see RL4
    else $error("clear-on-read left bits set");

  property p_set_wins;
    @(posedge ref_clk) disable iff (!rstn)
      (set_v[3] != 8'h00) |=> ((ev_q[3] & $past(set_v[3])) == $past(set_v[3]));
  endproperty
  a_set_wins: assert property (p_set_wins) // see RL17
    else $error("event lost against clear");

  property p_class_valid;
    @(posedge ref_clk) disable iff (!rstn)
      (port_evt.class_update != 4'h0) |=>
        ((ev_q[1][7:4] & ~$past(ev_q[1][7:4]) & ~$past(sig_valid)) == 4'h0);
  endproperty
  a_class_valid: assert property (p_class_valid) // see RL9
    else $error("class event without valid signature");

  property p_change_only;
    @(posedge ref_clk) disable iff (!rstn)
      (detect_change_only && port_evt.detect_update[0] && !ev_q[1][0] &&
       (port_evt.signature_result[0] == sig_q[0])) |=> !ev_q[1][0];
  endproperty
  a_change_only: assert property (p_change_only) // see RL7
    else $error("unchanged detection raised an event");

  property p_alert;
    @(posedge ref_clk) disable iff (!rstn)
      ##1 (!alert_n == |(event_summary & $past(summary_mask)));
  endproperty
  a_alert: assert property (p_alert) // see RL14
    else $error("alert does not match masked summary");

  property p_hold;
    @(posedge ref_clk) disable iff (!rstn)
      (ev_q[2] != 8'h00 && !rd_strobe && !clear_all && (port_clear == 4'h0))
        |=> ((ev_q[2] & $past(ev_q[2])) == $past(ev_q[2]));
  endproperty
  a_hold: assert property (p_hold) // see RL16
    else $error("latched event dropped without clear");

  property p_summary_probe;
    @(posedge ref_clk) disable iff (!rstn)
      ((|ev_q[1][7:4]) |-> event_summary[SUM_CLASS_DONE]) and
      ((|ev_q[1][3:0]) |-> event_summary[SUM_DETECT_DONE]);
  endproperty
  a_summary_probe: assert property (p_summary_probe) // see RL5 see RL8
    else $error("probe summary bit missing");

  property p_summary_fault;
    @(posedge ref_clk) disable iff (!rstn)
      ((|ev_q[2][7:4]) |-> event_summary[SUM_DISCONNECT]) and
      (((|ev_q[2][3:0]) || (|ev_q[3][7:4])) |-> event_summary[SUM_POWER_FAULT]) and
      ((|ev_q[3][3:0]) |-> event_summary[SUM_START_FAULT]);
  endproperty
  a_summary_fault: assert property (p_summary_fault) // see RL10 see RL11 see RL12 see RL13
    else $error("fault summary bit missing");

  property p_summary_clear;
    @(posedge ref_clk) disable iff (!rstn)
      (rd_strobe && (rd_addr == POWER_CHANGE_EVENTS_CLR) && (set_v[0] == 8'h00) &&
       !ext_summary[SUM_POWER_OK_CHANGE] && !ext_summary[SUM_SWITCH_ON_CHANGE]) |=>
        (!event_summary[SUM_POWER_OK_CHANGE] && !event_summary[SUM_SWITCH_ON_CHANGE]);
  endproperty
  a_summary_clear: assert property (p_summary_clear) // see RL15
    else $error("summary bit kept after clear-on-read");

  property p_detect_set;
    @(posedge ref_clk) disable iff (!rstn)
      (!detect_change_only && (port_evt.detect_update != 4'h0)) |=>
        ((ev_q[1][3:0] & $past(port_evt.detect_update)) == $past(port_evt.detect_update));
  endproperty
  a_detect_set: assert property (p_detect_set) // see RL6
    else $error("detection update not latched");

  property p_rd_latency;
    @(posedge ref_clk) disable iff (!rstn)
      rstn |=> (rd_valid == $past(rd_strobe));
  endproperty
  a_rd_latency: assert property (p_rd_latency) // see RL4
    else $error("read answer not one cycle after strobe");

  c_clr_read:   cover property (@(posedge ref_clk) disable iff (!rstn)
                  rd_strobe && is_clr_view(rd_addr) && (ev_q[group_of(rd_addr)] != 8'h00));
  c_set_clear:  cover property (@(posedge ref_clk) disable iff (!rstn)
                  rd_strobe && is_clr_view(rd_addr) && (set_v[group_of(rd_addr)] != 8'h00));
  c_alert:      cover property (@(posedge ref_clk) disable iff (!rstn)
                  $fell(alert_n));
  c_start_flt:  cover property (@(posedge ref_clk) disable iff (!rstn)
                  set_v[3][3:0] != 4'h0);
  c_chg_only:   cover property (@(posedge ref_clk) disable iff (!rstn)
                  detect_change_only && (port_evt.detect_update != 4'h0));

endmodule // pel_port_event_latches

`default_nettype wire

/* File: shared/pel_pkg.sv */
// Purpose: constants and carrier types for the per-quad port event latch bank
// Assumes: one quad of four ports, 8-bit registers on a byte-wide read port
// Notes:   register offsets are byte addresses on the serial register map
package pel_pkg;

  localparam int unsigned NUM_PORTS   = 4;
  localparam int unsigned NUM_GROUPS  = 4;

  // event registers; each read-only view is followed by its clear-on-read view
  localparam logic [7:0] POWER_CHANGE_EVENTS       = 8'h02;
  localparam logic [7:0] POWER_CHANGE_EVENTS_CLR   = 8'h03;
  localparam logic [7:0] PROBE_FINISH_EVENTS       = 8'h04;
  localparam logic [7:0] PROBE_FINISH_EVENTS_CLR   = 8'h05;
  localparam logic [7:0] DROP_OVERPOWER_EVENTS     = 8'h06;
  localparam logic [7:0] DROP_OVERPOWER_EVENTS_CLR = 8'h07;
  localparam logic [7:0] CURRENT_TRIP_EVENTS       = 8'h08;
  localparam logic [7:0] CURRENT_TRIP_EVENTS_CLR   = 8'h09;
  localparam logic [7:0] EVENT_BASE                = POWER_CHANGE_EVENTS;
  localparam logic [7:0] EVENT_LAST                = CURRENT_TRIP_EVENTS_CLR;

  // field positions inside each event register
  localparam int unsigned HI_FIELD_LSB = 4;
  localparam int unsigned LO_FIELD_LSB = 0;

  localparam logic [7:0] EVENT_RESET   = 8'h00;
  localparam logic [7:0] SUMMARY_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE     = 8'h00;

  // summary register bit positions
  localparam int unsigned SUM_SWITCH_ON_CHANGE = 0;
  localparam int unsigned SUM_POWER_OK_CHANGE  = 1;
  localparam int unsigned SUM_DISCONNECT       = 2;
  localparam int unsigned SUM_DETECT_DONE      = 3;
  localparam int unsigned SUM_CLASS_DONE       = 4;
  localparam int unsigned SUM_POWER_FAULT      = 5;
  localparam int unsigned SUM_START_FAULT      = 6;
  localparam int unsigned SUM_SUPPLY           = 7;

  // signature_result codes
  localparam logic [3:0] SIGNATURE_UNKNOWN = 4'h0;
  localparam logic [3:0] VALID_SIGNATURE   = 4'h4;

  // one-cycle event pulses and results from the port state machines
  typedef struct packed {
    logic [3:0]      maintain_loss_drop;
    logic [3:0]      overpower_trip;
    logic [3:0]      overcurrent_trip;
    logic [3:0]      inrush_trip;
    logic [3:0]      class_update;
    logic [3:0]      detect_update;
    logic [3:0][3:0] signature_result;
  } pel_port_evt_type;

endpackage

/* File: bench/pel_host_model.sv */
// Purpose: register reader standing in for the host behind the serial interface
// Assumes: req is a one-cycle pulse from the bench, one read outstanding at a time
// Notes:   address is inverted on every idle cycle, so a stale address returns only on alternate cycles
`timescale 1ns/10ps
`default_nettype none

module pel_host_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // bench side
  input  wire logic       req,
  input  wire logic [7:0] req_addr,
  output logic            got,
  output logic      [7:0] got_data,
  // design side
  output logic            rd_strobe,
  output logic      [7:0] rd_addr,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_strobe <= 1'b0;
      rd_addr   <= 8'h00;
      got       <= 1'b0;
      got_data  <= 8'h00;
    end else begin
      rd_strobe <= req;
      // released address bus shows garbage, not the last value
      rd_addr   <= req ? req_addr : ~rd_addr;
      got       <= rd_valid;
      got_data  <= rd_data;
    end
  end
endmodule // pel_host_model

`default_nettype wire

/* File: bench/pel_port_event_latches_tb.sv */
// Purpose: self-checking bench for the quad event latch bank
// Assumes: reads go through the host model, one byte per read
// Notes:   events are one-cycle pulses driven on the rising edge
`timescale 1ns/10ps
`default_nettype none

module pel_port_event_latches_tb;
  import pel_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, req = 1'b0, got, rd_strobe, rd_valid, alert_n;
  logic detect_change_only = 1'b0, clear_all = 1'b0;
  logic [3:0] power_ok = 4'h0, switch_on = 4'h0, port_clear = 4'h0;
  logic [7:0] summary_mask = 8'hff, ext_summary = 8'h00, req_addr = 8'h00;
  logic [7:0] got_data, rd_addr, rd_data, event_summary;
  pel_port_evt_type port_evt = '0;
  pel_port_evt_type ev;
  int err_count = 0, compares = 0;

  always #20 ref_clk = ~ref_clk;

  pel_port_event_latches DUT (.ref_clk(ref_clk), .rstn(rstn), .power_ok(power_ok),
    .switch_on(switch_on), .port_evt(port_evt), .detect_change_only(detect_change_only),
    .port_clear(port_clear), .clear_all(clear_all), .summary_mask(summary_mask),
    .ext_summary(ext_summary), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .event_summary(event_summary),
    .alert_n(alert_n));
  pel_host_model host (.ref_clk(ref_clk), .rstn(rstn), .req(req), .req_addr(req_addr),
    .got(got), .got_data(got_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid));

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_got(input logic [7:0] exp);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      #1;
      if (got === 1'b1) begin
        chk("read data", exp, got_data);
        return;
      end
    end
    err_count++;
    close_out();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    req      <= 1'b1;
    req_addr <= a;
    @(posedge ref_clk);
    req <= 1'b0;
    wait_got(exp);
  endtask

  // one-cycle pulse; signature levels stay behind afterwards
  task automatic pulse(input pel_port_evt_type v);
    @(posedge ref_clk);
    port_evt <= v;
    @(posedge ref_clk);
    port_evt <= {24'h0, v.signature_result};
  endtask

  task automatic status(input logic [7:0] sum, input logic al);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("summary", sum, event_summary);
    chk("alert_n", {7'h0, al}, {7'h0, alert_n});
  endtask

  task automatic t_reset();
    for (int a = 0; a < 12; a++) rd(8'(a), 8'h00);
    status(8'h00, 1'b1);
  endtask

  task automatic t_power();
    @(posedge ref_clk);
    power_ok  <= 4'h1;
    switch_on <= 4'h8;
    rd(8'h02, 8'h18);
    rd(8'h02, 8'h18);
    status(8'h03, 1'b0);
    summary_mask <= 8'hfc;
    status(8'h03, 1'b1);
    summary_mask <= 8'h02;
    status(8'h03, 1'b0);
    rd(8'h03, 8'h18);
    rd(8'h02, 8'h00);
    status(8'h00, 1'b1);
  endtask

  task automatic t_probe();
    ev = '0;
    summary_mask <= 8'hff;
    ev.signature_result = {4'h1, 4'h4, 4'h1, 4'h4};
    ev.class_update = 4'h6;
    ev.detect_update = 4'h1;
    pulse(ev);
    status(8'h18, 1'b0);
    rd(8'h05, 8'h41);
    detect_change_only <= 1'b1;
    ev.class_update = 4'h0;
    pulse(ev);
    rd(8'h04, 8'h00);
    ev.signature_result[0] = 4'h1;
    pulse(ev);
    rd(8'h05, 8'h01);
    status(8'h00, 1'b1);
  endtask

  task automatic t_fault();
    ev = '0;
    ev.maintain_loss_drop = 4'h1;
    ev.overpower_trip = 4'h3;
    ev.overcurrent_trip = 4'h1;
    ev.inrush_trip = 4'h9;
    pulse(ev);
    rd(8'h06, 8'h11);
    rd(8'h08, 8'h18);
    status(8'h64, 1'b0);
    @(posedge ref_clk);
    port_clear <= 4'h8;
    @(posedge ref_clk);
    port_clear <= 4'h0;
    rd(8'h08, 8'h10);
    @(posedge ref_clk);
    clear_all <= 1'b1;
    @(posedge ref_clk);
    clear_all <= 1'b0;
    rd(8'h06, 8'h00);
    status(8'h00, 1'b1);
  endtask

  task automatic t_race();
    ev = '0;
    ev.inrush_trip = 4'h8;
    pulse(ev);
    @(posedge ref_clk);
    req      <= 1'b1;
    req_addr <= 8'h09;
    @(posedge ref_clk);
    req <= 1'b0;
    port_evt.overcurrent_trip <= 4'h1;
    @(posedge ref_clk);
    port_evt.overcurrent_trip <= 4'h0;
    wait_got(8'h08);
    rd(8'h08, 8'h10);
    rd(8'h09, 8'h10);
    ext_summary  <= 8'h80;
    summary_mask <= 8'h80;
    status(8'h80, 1'b0);
    // reset in mid-run; held levels raise fresh change events after it
    @(posedge ref_clk);
    rstn <= 1'b0;
    status(8'h00, 1'b1);
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h02, 8'h18);
    status(8'h83, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_power();
    t_probe();
    t_fault();
    t_race();
    close_out();
  end
endmodule // pel_port_event_latches_tb

`default_nettype wire
